/* File: logic/stgb_consts.svh */
// Purpose: Offsets, field positions, reset values and fixed codes
// Assumes: Byte addresses on the APB side, 32-bit registers
// Notes:   Definitions only
`ifndef STGB_CONSTS_SVH
`define STGB_CONSTS_SVH
`define STGB_ADDR_TIMING   16'h840C
`define STGB_ADDR_GBASE    16'h8414
`define STGB_ADDR_TAGIDX   16'h8418
`define STGB_ADDR_TAGACC   16'h841C
`define STGB_TIM_RESET     32'h2A73_3225
`define STGB_TIM_WMASK     32'h7FF7_7770
`define STGB_TIM_FIXED     4'h5
`define STGB_GB_RESET      32'h0000_0000
`define STGB_GB_WMASK      32'h0003_F7FF
`define STGB_IDX_RESET     32'h0000_0000
`define STGB_IDX_WMASK     32'h0000_03FF
`define STGB_RAS_LSB       20
`define STGB_RP_LSB        16
`define STGB_RCD_LSB       12
`define STGB_RRD_LSB       8
`define STGB_DPL_LSB       4
`define STGB_DIAG_PIN_BIT  17
`define STGB_DIAG_SHR_BIT  16
`define STGB_SEL_LSB       12
`define STGB_GBASE_W       11
`define STGB_GBASE_SHIFT   19
`define STGB_TAG_DIRTY     1
`define STGB_TAG_VALID     0
`define STGB_COL_LSB       3
`define STGB_LOI_BANK_LSB  10
`define STGB_HOI_BANK_LSB  27
`endif

/* File: logic/stgb_pkg.sv */
// Purpose: Shared types of the SDRAM timing and graphics base block
// Assumes: Nothing
// Notes:   Constants live in stgb_consts.svh
package stgb_pkg;
   typedef enum logic [2:0] {OP_NOP, OP_ACT, OP_RD, OP_WR, OP_PRE} stgb_op_e;
   typedef logic [1:0] stgb_bank_t;
endpackage

/* File: logic/stgb_tag_if.sv */
// Purpose: Link between the register file and the tag storage
// Assumes: Read data is combinational from the index
// Notes:   None
`timescale 1ns/1ps
interface stgb_tag_if #(parameter int IW = 10);
   logic [IW-1:0] index;
   logic          wrEn;
   logic [1:0]    wrData;
   logic [1:0]    rdData;
   modport ctrl(output index, output wrEn, output wrData, input rdData);
   modport mem(input index, input wrEn, input wrData, output rdData);
endinterface

/* File: logic/stgb_bank_timer.sv */
// Purpose: Down counter that holds off a dependent command
// Assumes: load carries clocks minus one
// Notes:   ready is high once the count has run out
`timescale 1ns/1ps
module stgb_bank_timer #(parameter int CW = 4) (
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          load,
   input  wire logic [CW-1:0] loadVal,
   output logic               ready
);
   logic [CW-1:0] count;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= '0;
      end else if (load) begin
         count <= loadVal;
      end else if (count != '0) begin
         count <= count - 1'b1;
      end
   end

   assign ready = (count == '0);

   a_timer_countdown: assert property (@(posedge clk) disable iff (!rst_n)
      load && loadVal == CW'(3) |=> !ready ##1 !ready ##1 !ready ##1 ready)
      else $error("Timer did not run out after the loaded count");
endmodule

/* File: logic/stgb_tag_ram.sv */
// Purpose: Dirty and valid bits of the tag store
// Assumes: One entry written per cycle at most
// Notes:   Cleared at reset
`timescale 1ns/1ps
module stgb_tag_ram #(parameter int DEPTH = 1024) (
   input  wire logic clk,
   input  wire logic rst_n,
   stgb_tag_if.mem   tagPort
);
   logic [1:0] entry [DEPTH];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            entry[i] <= 2'b00;
         end
      end else if (tagPort.wrEn) begin
         entry[tagPort.index] <= tagPort.wrData;
      end
   end

   assign tagPort.rdData = entry[tagPort.index];

   a_tag_write_lands: assert property (@(posedge clk) disable iff (!rst_n)
      tagPort.wrEn |=> entry[$past(tagPort.index)] == $past(tagPort.wrData))
      else $error("Tag entry did not take the written bits");
endmodule

/* File: logic/stgb_top.sv */
// Purpose: SDRAM timing gate, diagnostic pins, graphics base and tag access
// Assumes: APB slave, one clock, requests held until granted
// Notes:   Commands leave registered; one command at most every two cycles
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "stgb_consts.svh"
module stgb_top #(
   parameter int NBANK = 4,
   parameter int TAGN  = 1024
) (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [15:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 reqValid,
   input  wire stgb_pkg::stgb_op_e   reqOp,
   input  wire logic [29:0]          reqAddr,
   input  wire logic [7:0]           reqByteEn,
   input  wire logic [1:0]           pageSizeCode,
   input  wire logic [1:0]           pairInstalled,
   output logic                      reqGrant,
   output stgb_pkg::stgb_op_e        cmdOp,
   output stgb_pkg::stgb_bank_t      cmdBank,
   output logic      [12:0]          rowAddr,
   output logic      [8:0]           colAddr,
   output logic      [7:0]           dqMask,
   output logic                      rowStrobeB,
   output logic                      colStrobeB,
   output logic                      clkEnableB,
   output logic                      writeEnB,
   output logic      [3:0]           diagTest,
   output logic      [29:0]          gfxBaseAddr,
   output logic                      loiActive
);
   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [31:0]          sdramTimingSecond;
   logic [31:0]          graphicsBaseCtrl;
   logic [31:0]          dirtyTagIndex;
   logic                 apbWrite;
   logic                 apbSetup;
   logic                 addrHit;
   logic [31:0]          next_prdata;
   stgb_tag_if #(.IW(10)) tagBus();

   assign apbSetup = psel && !penable;
   assign apbWrite = psel && penable && pready && pwrite;
   assign addrHit  = (paddr == `STGB_ADDR_TIMING) || (paddr == `STGB_ADDR_GBASE)
                  || (paddr == `STGB_ADDR_TAGIDX) || (paddr == `STGB_ADDR_TAGACC);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sdramTimingSecond <= `STGB_TIM_RESET;
      end else if (apbWrite && paddr == `STGB_ADDR_TIMING) begin
         sdramTimingSecond <= (pwdata & `STGB_TIM_WMASK)
                            | {28'h000_0000, `STGB_TIM_FIXED};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         graphicsBaseCtrl <= `STGB_GB_RESET;
      end else if (apbWrite && paddr == `STGB_ADDR_GBASE) begin
         graphicsBaseCtrl <= pwdata & `STGB_GB_WMASK;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dirtyTagIndex <= `STGB_IDX_RESET;
      end else if (apbWrite && paddr == `STGB_ADDR_TAGIDX) begin
         dirtyTagIndex <= pwdata & `STGB_IDX_WMASK;
      end
   end

   assign tagBus.index  = dirtyTagIndex[9:0];
   assign tagBus.wrEn   = apbWrite && paddr == `STGB_ADDR_TAGACC;
   assign tagBus.wrData = {pwdata[`STGB_TAG_DIRTY], pwdata[`STGB_TAG_VALID]};

   stgb_tag_ram #(.DEPTH(TAGN)) u_tagRam (
      .clk     (clk),
      .rst_n   (rst_n),
      .tagPort (tagBus.mem)
   );

   always_comb begin
      case (paddr)
         `STGB_ADDR_TIMING: next_prdata = {sdramTimingSecond[31:4], `STGB_TIM_FIXED};
         `STGB_ADDR_GBASE:  next_prdata = graphicsBaseCtrl;
         `STGB_ADDR_TAGIDX: next_prdata = dirtyTagIndex;
         `STGB_ADDR_TAGACC: next_prdata = {30'h0000_0000, tagBus.rdData};
         default:           next_prdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= apbSetup;
         pslverr <= apbSetup && !addrHit;
         if (apbSetup && !pwrite) begin
            prdata <= next_prdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timing codes to clock counts less one
   function automatic logic [3:0] holdOf(input logic [3:0] code, input logic plusOne);
      logic [4:0] clocks;
      clocks = {1'b0, code} + {4'h0, plusOne};
      if (code == 4'h0) begin
         clocks = 5'h01;
      end
      return 4'(clocks - 5'h01);
   endfunction

   logic [3:0] rasHold;
   logic [3:0] rpHold;
   logic [3:0] rcdHold;
   logic [3:0] rrdHold;
   logic [3:0] dplHold;

   assign rasHold = holdOf(sdramTimingSecond[`STGB_RAS_LSB +: 4], 1'b1);
   assign rpHold  = holdOf({1'b0, sdramTimingSecond[`STGB_RP_LSB +: 3]}, 1'b0);
   assign rcdHold = holdOf({1'b0, sdramTimingSecond[`STGB_RCD_LSB +: 3]}, 1'b0);
   assign rrdHold = holdOf({1'b0, sdramTimingSecond[`STGB_RRD_LSB +: 3]}, 1'b0);
   assign dplHold = holdOf({1'b0, sdramTimingSecond[`STGB_DPL_LSB +: 3]}, 1'b0);

   ////////////////////////////////////////////////////////////////////////////
   // Address translation
   logic                 reqPair;
   logic                 reqLoi;
   logic [4:0]           bankLsb;
   logic [4:0]           rowLsb;
   stgb_pkg::stgb_bank_t reqBank;

   assign reqPair = reqAddr[`STGB_HOI_BANK_LSB + 1];
   assign reqLoi  = pairInstalled[reqPair];
   assign bankLsb = 5'(`STGB_LOI_BANK_LSB) + {3'b000, pageSizeCode};
   assign reqBank = reqLoi ? {reqPair, reqAddr[bankLsb]}
                           : reqAddr[`STGB_HOI_BANK_LSB +: 2];
   assign rowLsb  = reqLoi ? bankLsb + 5'h01 : bankLsb;

   ////////////////////////////////////////////////////////////////////////////
   // Per-bank timers and the shared activate spacing timer
   logic                 issueNow;
   logic                 canIssue;
   logic                 rrdReady;
   logic [NBANK-1:0]     rasReady;
   logic [NBANK-1:0]     rpReady;
   logic [NBANK-1:0]     rcdReady;
   logic [NBANK-1:0]     dplReady;
   logic [NBANK-1:0]     bankHit;

   for (genvar b = 0; b < NBANK; b++) begin : g_bank
      assign bankHit[b] = issueNow && reqBank == 2'(b);
      stgb_bank_timer u_ras (
         .clk     (clk),
         .rst_n   (rst_n),
         .load    (bankHit[b] && reqOp == stgb_pkg::OP_ACT),
         .loadVal (rasHold),
         .ready   (rasReady[b])
      );
      stgb_bank_timer u_rp (
         .clk     (clk),
         .rst_n   (rst_n),
         .load    (bankHit[b] && reqOp == stgb_pkg::OP_PRE),
         .loadVal (rpHold),
         .ready   (rpReady[b])
      );
      stgb_bank_timer u_rcd (
         .clk     (clk),
         .rst_n   (rst_n),
         .load    (bankHit[b] && reqOp == stgb_pkg::OP_ACT),
         .loadVal (rcdHold),
         .ready   (rcdReady[b])
      );
      stgb_bank_timer u_dpl (
         .clk     (clk),
         .rst_n   (rst_n),
         .load    (bankHit[b] && reqOp == stgb_pkg::OP_WR),
         .loadVal (dplHold),
         .ready   (dplReady[b])
      );
   end

   stgb_bank_timer u_rrd (
      .clk     (clk),
      .rst_n   (rst_n),
      .load    (issueNow && reqOp == stgb_pkg::OP_ACT),
      .loadVal (rrdHold),
      .ready   (rrdReady)
   );

   always_comb begin
      case (reqOp)
         stgb_pkg::OP_ACT: canIssue = rpReady[reqBank] && rrdReady;
         stgb_pkg::OP_RD:  canIssue = rcdReady[reqBank];
         stgb_pkg::OP_WR:  canIssue = rcdReady[reqBank];
         stgb_pkg::OP_PRE: canIssue = rasReady[reqBank] && dplReady[reqBank];
         default:          canIssue = 1'b1;
      endcase
   end

   assign issueNow = reqValid && !reqGrant && canIssue;

   ////////////////////////////////////////////////////////////////////////////
   // Command outputs
   logic [3:0] debugNibble;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reqGrant  <= 1'b0;
         cmdOp     <= stgb_pkg::OP_NOP;
         cmdBank   <= 2'b00;
         rowAddr   <= 13'h0000;
         colAddr   <= 9'h000;
         dqMask    <= 8'hFF;
         loiActive <= 1'b0;
      end else begin
         reqGrant <= issueNow;
         cmdOp    <= issueNow ? reqOp : stgb_pkg::OP_NOP;
         if (issueNow) begin
            cmdBank   <= reqBank;
            rowAddr   <= 13'(reqAddr >> rowLsb);
            colAddr   <= reqAddr[`STGB_COL_LSB +: 9];
            dqMask    <= ~reqByteEn;
            loiActive <= reqLoi;
         end
      end
   end

   always_comb begin
      case (graphicsBaseCtrl[`STGB_SEL_LSB +: 4])
         4'h0:    debugNibble = {rrdReady, 3'(cmdOp)};
         4'h1:    debugNibble = rasReady;
         4'h2:    debugNibble = rpReady;
         4'h3:    debugNibble = rcdReady;
         4'h4:    debugNibble = dplReady;
         default: debugNibble = {loiActive, reqGrant, cmdBank};
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rowStrobeB <= 1'b1;
         colStrobeB <= 1'b1;
         clkEnableB <= 1'b1;
         writeEnB   <= 1'b1;
      end else if (graphicsBaseCtrl[`STGB_DIAG_SHR_BIT]) begin
         {rowStrobeB, colStrobeB, clkEnableB, writeEnB} <= debugNibble;
      end else begin
         clkEnableB <= 1'b1;
         rowStrobeB <= !(issueNow && (reqOp == stgb_pkg::OP_ACT
                                   || reqOp == stgb_pkg::OP_PRE));
         colStrobeB <= !(issueNow && (reqOp == stgb_pkg::OP_RD
                                   || reqOp == stgb_pkg::OP_WR));
         writeEnB   <= !(issueNow && (reqOp == stgb_pkg::OP_WR
                                   || reqOp == stgb_pkg::OP_PRE));
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         diagTest    <= 4'h0;
         gfxBaseAddr <= 30'h0000_0000;
      end else begin
         diagTest    <= graphicsBaseCtrl[`STGB_DIAG_PIN_BIT] ? debugNibble : 4'h0;
         gfxBaseAddr <= {graphicsBaseCtrl[`STGB_GBASE_W-1:0],
                         19'h0_0000};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   logic [4:0] ageAct [NBANK];
   logic [4:0] agePre [NBANK];
   logic [4:0] ageWr  [NBANK];
   logic [4:0] ageAnyAct;

   function automatic logic [4:0] ageStep(input logic clr, input logic [4:0] age);
      return clr ? 5'h00 : ((age == 5'h1F) ? age : age + 5'h01);
   endfunction

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ageAnyAct <= 5'h1F;
         for (int b = 0; b < NBANK; b++) begin
            ageAct[b] <= 5'h1F;
            agePre[b] <= 5'h1F;
            ageWr[b]  <= 5'h1F;
         end
      end else begin
         ageAnyAct <= ageStep(issueNow && reqOp == stgb_pkg::OP_ACT, ageAnyAct);
         for (int b = 0; b < NBANK; b++) begin
            ageAct[b] <= ageStep(bankHit[b] && reqOp == stgb_pkg::OP_ACT, ageAct[b]);
            agePre[b] <= ageStep(bankHit[b] && reqOp == stgb_pkg::OP_PRE, agePre[b]);
            ageWr[b]  <= ageStep(bankHit[b] && reqOp == stgb_pkg::OP_WR, ageWr[b]);
         end
      end
   end

   a_act_to_pre: assert property (@(posedge clk) disable iff (!rst_n)
      issueNow && reqOp == stgb_pkg::OP_PRE |-> ageAct[reqBank] >= {1'b0, rasHold})
      else $error("Precharge came too soon after activate");
   a_pre_to_act: assert property (@(posedge clk) disable iff (!rst_n)
      issueNow && reqOp == stgb_pkg::OP_ACT |-> agePre[reqBank] >= {1'b0, rpHold})
      else $error("Activate came too soon after precharge");
   a_act_to_rw: assert property (@(posedge clk) disable iff (!rst_n)
      issueNow && (reqOp == stgb_pkg::OP_RD || reqOp == stgb_pkg::OP_WR)
      |-> ageAct[reqBank] >= {1'b0, rcdHold})
      else $error("Read or write came too soon after activate");
   a_act_spacing: assert property (@(posedge clk) disable iff (!rst_n)
      issueNow && reqOp == stgb_pkg::OP_ACT |-> ageAnyAct >= {1'b0, rrdHold})
      else $error("Activates spaced too closely");
   a_write_to_pre: assert property (@(posedge clk) disable iff (!rst_n)
      issueNow && reqOp == stgb_pkg::OP_PRE |-> ageWr[reqBank] >= {1'b0, dplHold})
      else $error("Precharge came too soon after write");
   a_fixed_bits: assert property (@(posedge clk) disable iff (!rst_n)
      pready && !pwrite && paddr == `STGB_ADDR_TIMING |-> prdata[3:0] == `STGB_TIM_FIXED)
      else $error("Fixed timing bits read wrong");
   a_diag_low: assert property (@(posedge clk) disable iff (!rst_n)
      !graphicsBaseCtrl[`STGB_DIAG_PIN_BIT] |=> diagTest == 4'h0)
      else $error("Diagnostic pins not low while disabled");
   a_shared_normal: assert property (@(posedge clk) disable iff (!rst_n)
      !graphicsBaseCtrl[`STGB_DIAG_SHR_BIT] && issueNow && reqOp == stgb_pkg::OP_ACT
      |=> !rowStrobeB && colStrobeB && writeEnB && clkEnableB)
      else $error("Activate not shown on shared pins");
   a_gfx_base: assert property (@(posedge clk) disable iff (!rst_n)
      $changed(graphicsBaseCtrl) |=> gfxBaseAddr[29:19] == $past(graphicsBaseCtrl[10:0])
      && gfxBaseAddr[18:0] == 19'h0_0000)
      else $error("Graphics base not placed at bits 29 to 19");
   a_index_still: assert property (@(posedge clk) disable iff (!rst_n)
      !(apbWrite && paddr == `STGB_ADDR_TAGIDX) |=> $stable(dirtyTagIndex))
      else $error("Tag index moved without a write");
   a_tag_read: assert property (@(posedge clk) disable iff (!rst_n)
      apbSetup && !pwrite && paddr == `STGB_ADDR_TAGACC |=> prdata == {30'h0, $past(tagBus.rdData)})
      else $error("Tag access read wrong bits");
   a_bank_select: assert property (@(posedge clk) disable iff (!rst_n)
      issueNow && !reqLoi |=> cmdBank == $past(reqAddr[28:27]))
      else $error("High order bank not from top bits");
   a_grant_spacing: assert property (@(posedge clk) disable iff (!rst_n)
      reqGrant |=> !reqGrant && cmdOp == stgb_pkg::OP_NOP)
      else $error("Back to back issue");
endmodule

/* File: dv/stgb_sdram_model.sv */
// Purpose: Module side of the bus, decodes the command pins
// Assumes: Shared diagnostic pins off
// Notes:   Pins are active low
`timescale 1ns/1ps
module stgb_sdram_model (
   input  wire logic          rowStrobeB,
   input  wire logic          colStrobeB,
   input  wire logic          writeEnB,
   output stgb_pkg::stgb_op_e seenOp
);
   always_comb begin
      case ({rowStrobeB, colStrobeB, writeEnB})
         3'b011:  seenOp = stgb_pkg::OP_ACT;
         3'b101:  seenOp = stgb_pkg::OP_RD;
         3'b100:  seenOp = stgb_pkg::OP_WR;
         3'b010:  seenOp = stgb_pkg::OP_PRE;
         default: seenOp = stgb_pkg::OP_NOP;
      endcase
   end
endmodule

/* File: dv/tb_top.sv */
// Purpose: Self-checking bench of the timing and graphics base block
// Assumes: APB answers with one access cycle
// Notes:   Expected values kept in bench variables
`timescale 1ns/1ps
`include "stgb_consts.svh"
module tb_top;
   logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, reqValid = 0;
   logic [15:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd, g, lfsr = 32'h8d9a_055c;
   logic pready, pslverr, err, reqGrant, rowStrobeB, colStrobeB, clkEnableB, writeEnB;
   logic loiActive;
   stgb_pkg::stgb_op_e reqOp = stgb_pkg::OP_NOP, cmdOp, seenOp;
   stgb_pkg::stgb_bank_t cmdBank;
   logic [29:0] reqAddr = 0, gfxBaseAddr;
   logic [7:0] reqByteEn = 8'hFF, dqMask;
   logic [1:0] pageSizeCode = 0, pairInstalled = 0;
   logic [12:0] rowAddr;
   logic [8:0] colAddr;
   logic [3:0] diagTest;
   int err_total = 0, checked = 0;
   time t[7];
   always #5 clk = ~clk;
   stgb_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .reqValid(reqValid), .reqOp(reqOp), .reqAddr(reqAddr), .reqByteEn(reqByteEn),
      .pageSizeCode(pageSizeCode), .pairInstalled(pairInstalled), .reqGrant(reqGrant),
      .cmdOp(cmdOp), .cmdBank(cmdBank), .rowAddr(rowAddr), .colAddr(colAddr),
      .dqMask(dqMask), .rowStrobeB(rowStrobeB), .colStrobeB(colStrobeB),
      .clkEnableB(clkEnableB), .writeEnB(writeEnB), .diagTest(diagTest),
      .gfxBaseAddr(gfxBaseAddr), .loiActive(loiActive));
   stgb_sdram_model mem (.rowStrobeB(rowStrobeB), .colStrobeB(colStrobeB),
      .writeEnB(writeEnB), .seenOp(seenOp));
   ////////////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], 1'b0} ^ (v[31] ? 32'h0040_0007 : 32'h0000_0000);
   endfunction
   task automatic conclude();
      $display("errors %0d checks %0d", err_total, checked);
      if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkGap(input time a, input time b, input int n);
      checked++;
      if ((b - a) / 10 < n) begin
         err_total++;
         $display("FAIL %0t spacing %0d below %0d", $time, (b - a) / 10, n);
      end
   endtask
   task automatic hang();
      err_total++;
      $display("FAIL %0t no answer", $time);
      conclude();
   endtask
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      for (int i = 0; i < 20; i++) begin
         @(posedge clk);
         if (pready === 1'b1) begin
            rd = prdata;
            err = pslverr;
            psel <= 0;
            penable <= 0;
            return;
         end
      end
      hang();
   endtask
   task automatic issue(input stgb_pkg::stgb_op_e op, input logic [29:0] a, output time tg);
      @(posedge clk);
      reqValid <= 1;
      reqOp <= op;
      reqAddr <= a;
      for (int i = 0; i < 60; i++) begin
         @(posedge clk);
         if (reqGrant === 1'b1) begin
            tg = $time;
            reqValid <= 0;
            chk(cmdOp, op);
            chk(seenOp, op);
            chk(clkEnableB, 1);
            return;
         end
      end
      hang();
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1;
      apb(0, `STGB_ADDR_TIMING, 0);
      chk(rd, `STGB_TIM_RESET);
      apb(0, `STGB_ADDR_TAGIDX, 0);
      chk(rd, 0);
      for (int i = 0; i < 4; i++) begin
         lfsr = nxt(lfsr);
         g = (lfsr & `STGB_TIM_WMASK) | `STGB_TIM_FIXED;
         apb(1, `STGB_ADDR_TIMING, g);
         apb(0, `STGB_ADDR_TIMING, 0);
         chk(rd, g);
      end
      apb(0, 16'h8420, 0);
      chk({rd[30:0], err}, 1);
      lfsr = nxt(lfsr);
      g = (lfsr & 32'h0000_07FF) | 32'h0000_0400;
      apb(1, `STGB_ADDR_GBASE, g);
      repeat (2) @(posedge clk);
      chk(gfxBaseAddr, {g[10:0], 19'h0_0000});
      chk(diagTest, 0);
      apb(1, `STGB_ADDR_GBASE, g | 32'h0003_0000);
      repeat (3) @(posedge clk);
      chk(diagTest, 4'h8);
      chk({rowStrobeB, colStrobeB, clkEnableB, writeEnB}, 4'h8);
      apb(1, `STGB_ADDR_GBASE, g);
      apb(0, `STGB_ADDR_GBASE, 0);
      chk(rd, g);
      apb(1, `STGB_ADDR_TAGIDX, 5);
      apb(1, `STGB_ADDR_TAGACC, 2);
      apb(1, `STGB_ADDR_TAGIDX, 6);
      apb(1, `STGB_ADDR_TAGACC, 1);
      apb(0, `STGB_ADDR_TAGACC, 0);
      chk(rd, 1);
      apb(1, `STGB_ADDR_TAGIDX, 5);
      apb(0, `STGB_ADDR_TAGACC, 0);
      chk(rd, 2);
      apb(0, `STGB_ADDR_TAGIDX, 0);
      chk(rd, 5);
      apb(1, `STGB_ADDR_TIMING, 32'h0094_5545);
      lfsr = nxt(lfsr);
      reqByteEn <= lfsr[7:0];
      issue(stgb_pkg::OP_ACT, 30'h0000_0100, t[0]);
      issue(stgb_pkg::OP_RD, 30'h0000_0100, t[1]);
      chk({colAddr, dqMask}, {9'h020, ~lfsr[7:0]});
      issue(stgb_pkg::OP_WR, 30'h0000_0100, t[2]);
      issue(stgb_pkg::OP_PRE, 30'h0000_0100, t[3]);
      issue(stgb_pkg::OP_ACT, 30'h0000_0100, t[4]);
      issue(stgb_pkg::OP_ACT, 30'h0800_0000, t[5]);
      issue(stgb_pkg::OP_PRE, 30'h0800_0000, t[6]);
      chkGap(t[0], t[1], 5);
      chkGap(t[0], t[3], 10);
      chkGap(t[2], t[3], 4);
      chkGap(t[3], t[4], 4);
      chkGap(t[4], t[5], 5);
      chkGap(t[5], t[6], 10);
      chk({loiActive, cmdBank}, 3'h1);
      apb(1, `STGB_ADDR_TIMING, 32'h0094_5145);
      pairInstalled <= 2'h2;
      pageSizeCode <= 2'h2;
      issue(stgb_pkg::OP_ACT, 30'h1004_1000, t[0]);
      chk({loiActive, cmdBank}, 3'h7);
      chk(rowAddr, 13'h0020);
      pairInstalled <= 2'h0;
      issue(stgb_pkg::OP_ACT, 30'h1004_1000, t[1]);
      chk({loiActive, cmdBank}, 3'h2);
      chk(rowAddr, 13'h0041);
      conclude();
   end
endmodule
